// ---- chim_host.sv ----
// host model of the serial register bus, open-drain data
// assumes sda is the resolved wire with a pull-up
`timescale 1ns/1ps
module chim_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  // serial bus
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // released bus, clock parked high between frames
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // data moves mid low phase, clear of the device's 2-3 cycle lag
  task automatic bit_io(input logic b, output logic r);
    #25 sda_pull = !b;
    #25 scl = 1'b1;
    #15 r = sda;
    #15 scl = 1'b0;
  endtask
  // msb first, ninth bit carries the host ack when asked
  task automatic byte_io(input logic [7:0] d, input logic ack,
                         output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(!ack, r);
  endtask
  // start, also used as repeated start
  task automatic start_c();
    #25 sda_pull = 1'b0;
    #25 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop_c();
    #25 sda_pull = 1'b1;
    #25 scl = 1'b1;
    #40 sda_pull = 1'b0;
  endtask
  // one byte d at pointer p of device a
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d);
    logic [7:0] q;
    start_c();
    byte_io({a, 1'b0}, 1'b0, q);
    byte_io(p, 1'b0, q);
    byte_io(d, 1'b0, q);
    stop_c();
  endtask
  // two bytes from p, lower address into the low half
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    start_c();
    byte_io({DEV_ADDR, 1'b0}, 1'b0, v[7:0]);
    byte_io(p, 1'b0, v[7:0]);
    start_c();
    byte_io({DEV_ADDR, 1'b1}, 1'b0, v[7:0]);
    byte_io(8'hff, 1'b1, v[7:0]);
    byte_io(8'hff, 1'b0, v[15:8]);
    stop_c();
  endtask
endmodule // chim_host

// ---- chim_map.svh ----
// register map and timing constants of the charger mask and limit block
// assumes the includer compiles it once per unit; guarded anyway
`ifndef CHIM_MAP_SVH
`define CHIM_MAP_SVH

// register offsets on the serial bus
`define CHIM_CHARGE_STATE_IRQ_MASK_ADDR      8'h27
`define CHIM_FLT_MASK_ADDR      8'h28
`define CHIM_LIMIT_LO_ADDR      8'h29
`define CHIM_LIMIT_HI_ADDR      8'h2a

// reset values and writable bit patterns
`define CHIM_MASK_RESET         8'h00
`define CHIM_LIMIT_RESET        8'h00
`define CHIM_CHG_WR_BITS        8'h49
`define CHIM_FLT_WR_BITS        8'hf9

// charger mask field positions
`define CHIM_OPT_BIT            6
`define CHIM_CHG_BIT            3
`define CHIM_BUS_BIT            0
// fault mask field positions
`define CHIM_OVP_BIT            7
`define CHIM_BAT_BIT            6
`define CHIM_SYS_BIT            5
`define CHIM_BOOST_BIT          4
`define CHIM_DIE_BIT            3
`define CHIM_THERM_BIT          0

// optimizer code limits, 20 mA per step
`define CHIM_CODE_MIN           8'h05
`define CHIM_CODE_MAX           8'ha0
`define CHIM_CODE_LSB           4

// interrupt pulse width
`define CHIM_CLK_MHZ            100
`define CHIM_INT_PULSE_NS       1000
`define CHIM_INT_PULSE_CYC      ((`CHIM_INT_PULSE_NS * `CHIM_CLK_MHZ) / 1000)

`endif

// ---- chim_pkg.sv ----
// types shared by the charger mask and limit block
// assumes nothing beyond a SystemVerilog compiler
package chim_pkg;

  // serial slave protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_PTR,
    ST_ACK_PTR,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_ACK_RDATA
  } chim_state_e;

endpackage

// ---- chim_properties.sv ----
// checker for the mask and interrupt block, top ports only
// assumes one clk domain, nrst async low; bound from tb_top
`timescale 1ns/1ps
module chim_checker #(
  parameter int PULSE_CYC = 4
) (
  // clock, reset, serial pins
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  // event pulses
  input wire logic optimizer_state_chg,
  input wire logic charge_state_chg,
  input wire logic input_bus_state_chg,
  input wire logic input_overvolt_evt,
  input wire logic battery_fault_evt,
  input wire logic system_rail_fault_evt,
  input wire logic boost_output_fault_evt,
  input wire logic die_thermal_shutdown_evt,
  input wire logic thermistor_zone_chg,
  // interrupt pin
  input wire logic int_n
);
  logic       any_evt;
  logic [7:0] low_cnt;
  logic [7:0] since_evt;
  // masked events count too: masks are not visible here
  assign any_evt = optimizer_state_chg | charge_state_chg |
    input_bus_state_chg | input_overvolt_evt | battery_fault_evt |
    system_rail_fault_evt | boost_output_fault_evt |
    die_thermal_shutdown_evt | thermistor_zone_chg;
  // low run length, wrapping, and cycles since an event, saturating
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      low_cnt   <= 8'h00;
      since_evt <= 8'hff;
    end
    else
    begin
      low_cnt   <= int_n ? 8'h00 : low_cnt + 8'h01;
      since_evt <= any_evt ? 8'h00 : since_evt + {7'h0, since_evt != 8'hff};
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_scl_fall;
    $fell(scl_in);
  endsequence
  sequence s_oe_hold;
    $stable(sda_oe)[*2];
  endsequence
  a_reset_idle: assert property ($rose(nrst) |-> int_n && !sda_oe)
    else $error("outputs active after reset");
  a_fall_cause: assert property ($fell(int_n) |-> $past(any_evt))
    else $error("interrupt without event");
  a_quiet_hold: assert property (int_n && !any_evt |=> int_n)
    else $error("interrupt started idle");
  a_pulse_min: assert property ($rose(int_n) |-> low_cnt >= PULSE_CYC)
    else $error("interrupt pulse short");
  a_pulse_end: assert property (since_evt >= PULSE_CYC |-> int_n)
    else $error("interrupt pulse long");
  a_sda_settle: assert property (s_scl_fall |=> s_oe_hold)
    else $error("data drive moved early");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled with clock high");
  a_rel_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released with clock high");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
endmodule // chim_checker

// ---- chim_top.sv ----
// charger interrupt masks, optimizer limit readback and serial slave
// assumes event inputs are one-cycle pulses on clk; scl/sda are async pins
`timescale 1ns/1ps
`include "chim_map.svh"
// Functional notes
// - optimizer status change pulses interrupt only while charger mask bit 6 is 0
// - charging status change pulses interrupt only while charger mask bit 3 is 0
// - input bus status change pulses interrupt only while charger mask bit 0 is 0
// - input bus overvoltage entry interrupts only while fault mask bit 7 is 0
// - battery overcurrent or overvoltage interrupts only while fault mask bit 6 is 0
// - system overvoltage or short interrupts only while fault mask bit 5 is 0
// - boost output bus faults interrupt only while fault mask bit 4 is 0
// - die thermal shutdown interrupts only while fault mask bit 3 is 0
// - thermistor zone change interrupts only while fault mask bit 0 is 0
// - both mask registers reset to zero, also on register reset
// - optimizer limit code read in bits 11:4, 20 mA steps, 5h to a0h
// - limit register is little endian, low byte at lower address
// - each unmasked event starts or restarts the low pulse on the interrupt output
module chim_top #(
  parameter logic [6:0] DEV_ADDR  = 7'h2a, // arbitrary value
  parameter int         PULSE_CYC = `CHIM_INT_PULSE_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // charger events, one-cycle pulses
  input  wire logic       optimizer_state_chg,
  input  wire logic       charge_state_chg,
  input  wire logic       input_bus_state_chg,
  // fault events, one-cycle pulses
  input  wire logic       input_overvolt_evt,
  input  wire logic       battery_fault_evt,
  input  wire logic       system_rail_fault_evt,
  input  wire logic       boost_output_fault_evt,
  input  wire logic       die_thermal_shutdown_evt,
  input  wire logic       thermistor_zone_chg,
  // control from the rest of the charger
  input  wire logic       reg_reset,
  input  wire logic       adapter_unplug,
  input  wire logic       optimized_current_load,
  input  wire logic [7:0] optimized_current_in,
  // interrupt pin, active low
  output logic            int_n
);

  // pin synchronisers and edge history
  logic [1:0] scl_sync_r, sda_sync_r;
  logic       scl_d_r, sda_d_r;
  logic       scl_s, sda_s;
  logic       scl_rise, scl_fall;
  logic       bus_start, bus_stop;
  // protocol state
  chim_pkg::chim_state_e state_r, state_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] bitc_r, bitc_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       done_r, done_nxt;
  logic       rnw_r, rnw_nxt;
  logic       hack_r, hack_nxt;
  logic       oe_r, oe_nxt;
  logic       wr_stb;
  // register file and interrupt state
  logic [7:0] charge_state_irq_mask_r, charge_state_irq_mask_nxt;
  logic [7:0] flt_mask_r, flt_mask_nxt;
  logic [7:0] code_r, code_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  logic       int_n_r, int_n_nxt;
  logic       sda_out_r, hit;
  // read mux; reserved bits read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic [7:0] cm,
                                         input logic [7:0] fm,
                                         input logic [7:0] cd);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `CHIM_CHARGE_STATE_IRQ_MASK_ADDR: v = cm & `CHIM_CHG_WR_BITS;
      `CHIM_FLT_MASK_ADDR: v = fm & `CHIM_FLT_WR_BITS;
      `CHIM_LIMIT_LO_ADDR: v = {cd[3:0], 4'h0};
      `CHIM_LIMIT_HI_ADDR: v = {4'h0, cd[7:4]};
      default:             v = 8'h00;
    endcase
    return v;
  endfunction
  // second flop only feeds logic; first flop is never read elsewhere
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end
  // bus conditions seen on the sampled pins
  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign hit       = (sh_r[7:1] == DEV_ADDR);
  // serial slave next state; sda only changes after a falling scl edge
  always_comb
  begin
    state_nxt = state_r;
    sh_nxt    = sh_r;
    bitc_nxt  = bitc_r;
    ptr_nxt   = ptr_r;
    done_nxt  = done_r;
    rnw_nxt   = rnw_r;
    hack_nxt  = hack_r;
    oe_nxt    = oe_r;
    wr_stb    = 1'b0;
    if (bus_start)
    begin
      state_nxt = chim_pkg::ST_ADDR;
      bitc_nxt  = 3'h0;
      done_nxt  = 1'b0;
      oe_nxt    = 1'b0;
    end
    else if (bus_stop)
    begin
      state_nxt = chim_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
    end
    else
    begin
      case (state_r)
        chim_pkg::ST_IDLE: oe_nxt = 1'b0;
        chim_pkg::ST_ADDR, chim_pkg::ST_PTR, chim_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            sh_nxt   = {sh_r[6:0], sda_s};
            bitc_nxt = bitc_r + 3'h1;
            done_nxt = (bitc_r == 3'h7);
          end
          else if (scl_fall && done_r)
          begin
            done_nxt = 1'b0;
            oe_nxt   = 1'b1;  // acknowledge by pulling low
            if (state_r == chim_pkg::ST_ADDR)
            begin
              rnw_nxt   = sh_r[0];
              oe_nxt    = hit;  // a foreign address gets no ack
              state_nxt = hit ? chim_pkg::ST_ACK_ADDR : chim_pkg::ST_IDLE;
            end
            else if (state_r == chim_pkg::ST_PTR)
            begin
              ptr_nxt   = sh_r;
              state_nxt = chim_pkg::ST_ACK_PTR;
            end
            else
            begin
              wr_stb    = 1'b1;
              ptr_nxt   = ptr_r + 8'h01;  // auto increment
              state_nxt = chim_pkg::ST_ACK_WDATA;
            end
          end
        end
        chim_pkg::ST_ACK_ADDR, chim_pkg::ST_ACK_PTR,
        chim_pkg::ST_ACK_WDATA:
        begin
          if (scl_fall)
          begin
            bitc_nxt = 3'h0;
            oe_nxt   = 1'b0;
            if (state_r == chim_pkg::ST_ACK_ADDR && rnw_r)
            begin
              sh_nxt    = rd_byte(ptr_r, charge_state_irq_mask_r, flt_mask_r, code_r);
              ptr_nxt   = ptr_r + 8'h01;
              oe_nxt    = ~sh_nxt[7];
              state_nxt = chim_pkg::ST_RDATA;
            end
            else if (state_r == chim_pkg::ST_ACK_ADDR)
              state_nxt = chim_pkg::ST_PTR;
            else
              state_nxt = chim_pkg::ST_WDATA;
          end
        end
        chim_pkg::ST_RDATA:
          if (scl_fall)
          begin
            // the eighth falling edge releases sda for the host's ack
            sh_nxt   = {sh_r[6:0], 1'b0};
            oe_nxt   = (bitc_r != 3'h7) & ~sh_r[6];
            bitc_nxt = bitc_r + 3'h1;
            if (bitc_r == 3'h7)
              state_nxt = chim_pkg::ST_ACK_RDATA;
          end
        chim_pkg::ST_ACK_RDATA:
        begin
          if (scl_rise)
            hack_nxt = ~sda_s;
          else if (scl_fall)
          begin
            bitc_nxt = 3'h0;
            if (hack_r)
            begin
              sh_nxt    = rd_byte(ptr_r, charge_state_irq_mask_r, flt_mask_r, code_r);
              ptr_nxt   = ptr_r + 8'h01;  // low then high byte
              oe_nxt    = ~sh_nxt[7];
              state_nxt = chim_pkg::ST_RDATA;
            end
            else
              state_nxt = chim_pkg::ST_IDLE;  // host ended the read
          end
        end
        default: state_nxt = chim_pkg::ST_IDLE;  // idle then drops oe
      endcase
    end
  end
  // serial slave registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= chim_pkg::ST_IDLE;
      sh_r    <= 8'h00;
      bitc_r  <= 3'h0;
      ptr_r   <= 8'h00;
      done_r  <= 1'b0;
      rnw_r   <= 1'b0;
      hack_r  <= 1'b0;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sh_r    <= sh_nxt;
      bitc_r  <= bitc_nxt;
      ptr_r   <= ptr_nxt;
      done_r  <= done_nxt;
      rnw_r   <= rnw_nxt;
      hack_r  <= hack_nxt;
      oe_r    <= oe_nxt;
    end
  end
  // register file, limit code and interrupt pulse next values
  always_comb
  begin
    logic pend;
    pend         = 1'b0;
    charge_state_irq_mask_nxt = charge_state_irq_mask_r;
    flt_mask_nxt = flt_mask_r;
    code_nxt     = code_r;
    pcnt_nxt     = pcnt_r;
    int_n_nxt    = int_n_r;
    // writes touch only writable bits
    if (wr_stb && ptr_r == `CHIM_CHARGE_STATE_IRQ_MASK_ADDR)
      charge_state_irq_mask_nxt = sh_r & `CHIM_CHG_WR_BITS;
    if (wr_stb && ptr_r == `CHIM_FLT_MASK_ADDR)
      flt_mask_nxt = sh_r & `CHIM_FLT_WR_BITS;
    // register reset wins over a write in the same cycle
    if (reg_reset)
    begin
      charge_state_irq_mask_nxt = `CHIM_MASK_RESET;
      flt_mask_nxt = `CHIM_MASK_RESET;
    end
    // limit code: loads clamp, unplug clears, reg_reset ignored
    if (optimized_current_load)
      code_nxt = (optimized_current_in < `CHIM_CODE_MIN) ? `CHIM_CODE_MIN :
                 (optimized_current_in > `CHIM_CODE_MAX) ? `CHIM_CODE_MAX :
                 optimized_current_in;
    if (adapter_unplug)
      code_nxt = `CHIM_LIMIT_RESET;
    // gate each event with its mask bit
    pend = (optimizer_state_chg & ~charge_state_irq_mask_r[`CHIM_OPT_BIT])
         | (charge_state_chg & ~charge_state_irq_mask_r[`CHIM_CHG_BIT])
         | (input_bus_state_chg & ~charge_state_irq_mask_r[`CHIM_BUS_BIT])
         | (input_overvolt_evt & ~flt_mask_r[`CHIM_OVP_BIT])
         | (battery_fault_evt & ~flt_mask_r[`CHIM_BAT_BIT])
         | (system_rail_fault_evt & ~flt_mask_r[`CHIM_SYS_BIT])
         | (boost_output_fault_evt & ~flt_mask_r[`CHIM_BOOST_BIT])
         | (die_thermal_shutdown_evt & ~flt_mask_r[`CHIM_DIE_BIT])
         | (thermistor_zone_chg & ~flt_mask_r[`CHIM_THERM_BIT]);
    // fixed-width low pulse; a new event restarts it rather than merging
    if (pend)
    begin
      pcnt_nxt  = 16'(PULSE_CYC);
      int_n_nxt = 1'b0;
    end
    else if (pcnt_r > 16'h0001)
      pcnt_nxt = pcnt_r - 16'h0001;
    else
    begin
      pcnt_nxt  = 16'h0000;
      int_n_nxt = 1'b1;  // pulse ends without host action
    end
  end
  // register file and interrupt registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      charge_state_irq_mask_r <= `CHIM_MASK_RESET;
      flt_mask_r <= `CHIM_MASK_RESET;
      code_r     <= `CHIM_LIMIT_RESET;
      pcnt_r     <= 16'h0000;
      int_n_r    <= 1'b1;
      sda_out_r  <= 1'b0;
    end
    else
    begin
      charge_state_irq_mask_r <= charge_state_irq_mask_nxt;
      flt_mask_r <= flt_mask_nxt;
      code_r     <= code_nxt;
      pcnt_r     <= pcnt_nxt;
      int_n_r    <= int_n_nxt;
      sda_out_r  <= 1'b0;  // open drain: only ever pulls low
    end
  end
  // outputs straight from flops
  assign sda_out = sda_out_r;
  assign sda_oe  = oe_r;
  assign int_n   = int_n_r;

endmodule // chim_top

// ---- tb_top.sv ----
// self-checking bench for the charger mask and limit block
// assumes chim_host as bus partner, chim_checker bound below
`timescale 1ns/1ps
module tb_top;
  localparam int PULSE_CYC = 4;
  logic        clk = 1'b0;
  logic        nrst, sda_out, sda_oe, int_n, reg_reset, unplug, load;
  logic [8:0]  ev;
  logic [7:0]  code_in, cm, fm;
  logic [15:0] v;
  logic [7:0]  corner [6] = '{8'h00, 8'h04, 8'h05, 8'ha0, 8'ha1, 8'hff};
  int          fails, comparisons, seed;
  wire         scl, pull, sda;
  // open-drain data wire with pull-up
  assign sda = !pull && !(sda_oe && !sda_out);
  always #5 clk = !clk;
  chim_top #(.PULSE_CYC(PULSE_CYC)) i_chim_top (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .optimizer_state_chg(ev[0]),
    .charge_state_chg(ev[1]), .input_bus_state_chg(ev[2]),
    .input_overvolt_evt(ev[3]), .battery_fault_evt(ev[4]),
    .system_rail_fault_evt(ev[5]), .boost_output_fault_evt(ev[6]),
    .die_thermal_shutdown_evt(ev[7]), .thermistor_zone_chg(ev[8]),
    .reg_reset(reg_reset), .adapter_unplug(unplug),
    .optimized_current_load(load), .optimized_current_in(code_in),
    .int_n(int_n));
  chim_host i_chim_host (.scl(scl), .sda_pull(pull), .sda(sda));
  // mask bit gating each event line
  function automatic logic masked(input int i, input logic [7:0] c,
                                  input logic [7:0] f);
    logic [8:0] m;
    m = {f[0], f[3], f[4], f[5], f[6], f[7], c[0], c[3], c[6]};
    return m[i];
  endfunction
  // clamped code in bits 11:4, reserved bits zero
  function automatic logic [15:0] lim(input logic [7:0] c);
    logic [7:0] k;
    k = c < 8'h05 ? 8'h05 : (c > 8'ha0 ? 8'ha0 : c);
    return {4'h0, k, 4'h0};
  endfunction
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic sync();
    @(posedge clk);
    #1;
  endtask
  // one event pulse, then the exact interrupt pulse width
  task automatic fire(input int i);
    logic x;
    x = !masked(i, cm, fm);
    ev[i] = 1'b1;
    sync();
    ev[i] = 1'b0;
    check("int_n start", {15'h0, !x}, {15'h0, int_n});
    repeat (PULSE_CYC - 1) @(posedge clk);
    #1 check("int_n held", {15'h0, !x}, {15'h0, int_n});
    sync();
    check("int_n end", 16'h0001, {15'h0, int_n});
  endtask
  initial
  begin
    seed = 32'h93f9441a;
    {nrst, reg_reset, unplug, load} = 4'h0;
    {ev, code_in, cm, fm} = 33'h0;
    fails = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) sync();
    i_chim_host.rd(8'h27, v);
    check("masks reset", 16'h0000, v);
    i_chim_host.rd(8'h29, v);
    check("limit reset", 16'h0000, v);
    // all clear and all set first, then random masks
    for (int k = 0; k < 6; k++)
    begin
      cm = k < 2 ? {8{k[0]}} : 8'($random(seed));
      fm = k < 2 ? {8{k[0]}} : 8'($random(seed));
      i_chim_host.wr(7'h2a, 8'h27, cm);
      i_chim_host.wr(7'h2a, 8'h28, fm);
      i_chim_host.rd(8'h27, v);
      check("masks", {fm & 8'hf9, cm & 8'h49}, v);
      sync();
      for (int i = 0; i < 9; i++)
        fire(i);
    end
    // clamp corners, then random codes; writes here are dropped
    for (int k = 0; k < 10; k++)
    begin
      code_in = k < 6 ? corner[k] : 8'($random(seed));
      load = 1'b1;
      sync();
      load = 1'b0;
      i_chim_host.wr(7'h2a, 8'h29, 8'hff);
      i_chim_host.rd(8'h29, v);
      check("limit", lim(code_in), v);
      sync();
    end
    reg_reset = 1'b1;
    sync();
    reg_reset = 1'b0;
    i_chim_host.rd(8'h27, v);
    check("masks after reg reset", 16'h0000, v);
    i_chim_host.rd(8'h29, v);
    check("limit after reg reset", lim(code_in), v);
    sync();
    {cm, fm} = 16'h0000;
    fire(8);
    unplug = 1'b1;
    sync();
    unplug = 1'b0;
    i_chim_host.rd(8'h29, v);
    check("limit after unplug", 16'h0000, v);
    // a foreign address is ignored until the next start
    i_chim_host.wr(7'h55, 8'h27, 8'h49);
    i_chim_host.rd(8'h27, v);
    check("masks foreign addr", 16'h0000, v);
    // mid-run reset: masks and limit code go back to zero
    i_chim_host.wr(7'h2a, 8'h28, 8'hff);
    code_in = 8'h50;
    load = 1'b1;
    sync();
    load = 1'b0;
    i_chim_host.rd(8'h29, v);
    check("limit before nrst", lim(code_in), v);
    nrst = 1'b0;
    sync();
    nrst = 1'b1;
    repeat (4) sync();
    i_chim_host.rd(8'h27, v);
    check("masks after nrst", 16'h0000, v);
    i_chim_host.rd(8'h29, v);
    check("limit after nrst", 16'h0000, v);
    conclude();
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("ERROR run expected done seen hang");
    conclude();
  end
endmodule // tb_top
bind chim_top chim_checker #(.PULSE_CYC(PULSE_CYC)) i_chim_checker (
  .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_oe(sda_oe),
  .optimizer_state_chg(optimizer_state_chg),
  .charge_state_chg(charge_state_chg),
  .input_bus_state_chg(input_bus_state_chg),
  .input_overvolt_evt(input_overvolt_evt),
  .battery_fault_evt(battery_fault_evt),
  .system_rail_fault_evt(system_rail_fault_evt),
  .boost_output_fault_evt(boost_output_fault_evt),
  .die_thermal_shutdown_evt(die_thermal_shutdown_evt),
  .thermistor_zone_chg(thermistor_zone_chg), .sda_out(sda_out),
  .int_n(int_n));
